// ===== verilog/sadc_ctrl.sv
/*
  Successive-approximation converter controller with APB register slave.
  Assumes an analog front end that samples, holds and compares against the
  tap code it is given, returning a synchronous compare result each cycle.
*/
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "sadc_defs.svh"

module sadc_ctrl #(
  parameter int RES_BITS = 10,
  parameter int SCAN_CH = `SADC_SCAN_CH
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hwTrigger,
  input wire logic cmpAbove,
  output sadc_pkg::sadc_analog_s analogCtl,
  output logic conversionEndIrq
);

  // ========================================================================
  // Elaboration checks
  initial
  begin
    if (RES_BITS != 10)
    begin
      $error("sadc_ctrl serves only a 10-bit approximation register.");
    end
    if (SCAN_CH < 1 || SCAN_CH > 8)
    begin
      $error("sadc_ctrl scan count must be 1 to 8.");
    end
  end

  localparam int STAB_CYC = `SADC_STAB_CYC;
  localparam logic [4:0] GAIN_AMP_CH = 5'h1F;

  // ========================================================================
  // Registers
  logic [7:0] mode0;
  logic [7:0] mode1;
  logic [7:0] modeC;
  logic [4:0] chanSel;
  logic [7:0] upLimit;
  logic [7:0] loLimit;
  logic [15:0] resultWide;
  logic [7:0] resultNarrow;
  logic lastInRange;

  sadc_pkg::sadc_state_e state;
  logic [9:0] sar;
  logic [3:0] bitIdx;
  logic [5:0] cnt;
  logic [2:0] scanIdx;
  logic hwTrigDly;
  logic runClear;

  wire logic wrEn = psel && penable && pwrite;
  wire logic runBit = mode0[`SADC_M0_RUN];
  wire logic cmpEnBit = mode0[`SADC_M0_CMPEN];
  wire logic scanMode = mode0[`SADC_M0_CHMODE];
  wire logic oneShot = mode1[`SADC_M1_ONESHOT];
  wire logic res8 = modeC[`SADC_MC_RES8];
  wire logic trigEdge = hwTrigger && !hwTrigDly;
  wire sadc_pkg::sadc_trig_e trigMode =
    sadc_pkg::sadc_trig_e'(mode1[`SADC_M1_TRIG_LO +: 2]);
  // Run bit only counts while the comparator is enabled.
  // run with comparator
  wire logic active = runBit && cmpEnBit;

  // ========================================================================
  // Register address decode used only for the error response (pslverr) of reads and writes.
  function automatic logic isMapped(input logic [11:0] a);
    unique case (a)
      `SADC_OFS_MODE0, `SADC_OFS_MODE1, `SADC_OFS_MODEC, `SADC_OFS_CHAN,
      `SADC_OFS_RESW, `SADC_OFS_RESN, `SADC_OFS_UPLIM, `SADC_OFS_LOLIM,
      `SADC_OFS_STAT: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);

  // ========================================================================
  // Mode register 0 write; hardware clears run at end of one-shot.
  // one-shot stop
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode0 <= 8'h00;
    else if (wrEn && paddr == `SADC_OFS_MODE0)
      mode0 <= pwdata[7:0];
    else if (runClear)
      mode0[`SADC_M0_RUN] <= 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode1 <= 8'h00;
      modeC <= 8'h00;
      chanSel <= 5'h00;
      upLimit <= `SADC_UPLIM_RST;
      loLimit <= `SADC_LOLIM_RST;
    end
    else if (wrEn)
    begin
      unique case (paddr)
        `SADC_OFS_MODE1: mode1 <= pwdata[7:0];
        `SADC_OFS_MODEC: modeC <= pwdata[7:0];
        `SADC_OFS_CHAN: chanSel <= pwdata[4:0];
        `SADC_OFS_UPLIM: upLimit <= pwdata[7:0];
        `SADC_OFS_LOLIM: loLimit <= pwdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // ========================================================================
  // Read mux; data is registered on the setup cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `SADC_OFS_MODE0: prdata <= {24'h00_0000, mode0};
        `SADC_OFS_MODE1: prdata <= {24'h00_0000, mode1};
        `SADC_OFS_MODEC: prdata <= {24'h00_0000, modeC};
        `SADC_OFS_CHAN: prdata <= {27'h000_0000, chanSel};
        `SADC_OFS_RESW: prdata <= {16'h0000, resultWide};
        `SADC_OFS_RESN: prdata <= {24'h00_0000, resultNarrow};
        `SADC_OFS_UPLIM: prdata <= {24'h00_0000, upLimit};
        `SADC_OFS_LOLIM: prdata <= {24'h00_0000, loLimit};
        `SADC_OFS_STAT: prdata <= {28'h000_0000, lastInRange, scanIdx};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hwTrigDly <= 1'b0;
    else
      hwTrigDly <= hwTrigger;
  end

  // ========================================================================
  // Conversion sequencer.
  wire logic [5:0] sampleLen = mode0[`SADC_M0_SHORT] ?
    6'(`SADC_SAMPLE_SHORT) : 6'(`SADC_SAMPLE_LONG);
  wire logic [3:0] lastBit = res8 ? 4'd2 : 4'd0;
  wire logic lastScan = !scanMode || scanIdx == 3'(SCAN_CH - 1);
  wire logic [7:0] res8Val = sar[9:2];
  // Range test outside or inside selectable; keeps request off otherwise.
  // limit range check
  wire logic inRange = (res8Val <= upLimit) && (res8Val >= loLimit);
  wire logic passLimit = modeC[`SADC_MC_RANGEOUT] ? !inRange : inRange;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= sadc_pkg::SADC_IDLE;
      sar <= 10'h000;
      bitIdx <= 4'd0;
      cnt <= 6'd0;
      scanIdx <= 3'd0;
      runClear <= 1'b0;
      conversionEndIrq <= 1'b0;
      resultWide <= 16'h0000;
      resultNarrow <= 8'h00;
      lastInRange <= 1'b0;
    end
    else
    begin
      runClear <= 1'b0;
      conversionEndIrq <= 1'b0;
      if (!active)
      begin
        state <= sadc_pkg::SADC_IDLE;
        scanIdx <= 3'd0;
      end
      else
      begin
        unique case (state)
          sadc_pkg::SADC_IDLE:
          begin
            cnt <= 6'd0;
            // Run still reads set in the cycle after a one-shot pass, so hold off here.
            // no restart pending
            if (runClear)
              state <= sadc_pkg::SADC_IDLE;
            else if (trigMode == sadc_pkg::SADC_TRIG_SW)
              state <= sadc_pkg::SADC_SAMPLE;
            else if (trigMode == sadc_pkg::SADC_TRIG_HWNOWAIT && trigEdge)
              state <= sadc_pkg::SADC_SAMPLE;
            else if (trigMode == sadc_pkg::SADC_TRIG_HWWAIT && trigEdge)
              state <= sadc_pkg::SADC_STAB;
          end
          sadc_pkg::SADC_STAB:
          begin
            if (cnt == 6'(STAB_CYC - 1))
            begin
              cnt <= 6'd0;
              state <= sadc_pkg::SADC_SAMPLE;
            end
            else
              cnt <= cnt + 6'd1;
          end
          sadc_pkg::SADC_SAMPLE:
          begin
            if (cnt == sampleLen - 6'd1)
            begin
              cnt <= 6'd0;
              sar <= 10'h200;
              bitIdx <= 4'd9;
              state <= sadc_pkg::SADC_CONVERT;
            end
            else
              cnt <= cnt + 6'd1;
          end
          sadc_pkg::SADC_CONVERT:
          begin
            sar[bitIdx] <= cmpAbove;
            if (bitIdx == lastBit)
              state <= sadc_pkg::SADC_LOAD;
            else
            begin
              sar[bitIdx - 4'd1] <= 1'b1;
              bitIdx <= bitIdx - 4'd1;
            end
          end
          sadc_pkg::SADC_LOAD:
          begin
            resultWide <= {sar, 6'h00};
            resultNarrow <= sar[9:2];
            lastInRange <= inRange;
            if (lastScan)
              conversionEndIrq <= passLimit;
            scanIdx <= lastScan ? 3'd0 : scanIdx + 3'd1;
            if (lastScan && oneShot)
            begin
              runClear <= 1'b1;
              state <= sadc_pkg::SADC_IDLE;
            end
            else if (lastScan && trigMode != sadc_pkg::SADC_TRIG_SW)
              state <= sadc_pkg::SADC_IDLE;
            else
              state <= sadc_pkg::SADC_SAMPLE;
          end
          default: state <= sadc_pkg::SADC_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // Analog front-end steering.
  always_comb
  begin
    analogCtl.sampleOn = state == sadc_pkg::SADC_SAMPLE;
    analogCtl.compareOn = state == sadc_pkg::SADC_CONVERT;
    // Wait mode keeps the front end off until a trigger arrives.
    // standby unpowered
    analogCtl.powerOn = cmpEnBit &&
      (trigMode != sadc_pkg::SADC_TRIG_HWWAIT || state != sadc_pkg::SADC_IDLE);
    analogCtl.channel = scanMode ? chanSel + 5'(scanIdx) : chanSel;
    analogCtl.tapCode = sar;
    analogCtl.refSel = {modeC[`SADC_MC_REFHI], modeC[`SADC_MC_REFLO]};
    if (!scanMode && chanSel == GAIN_AMP_CH)
      analogCtl.channel = GAIN_AMP_CH;
  end

endmodule

// ===== verilog/sadc_defs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  converter controller. Assumes inclusion by bare name from the design files.
*/
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses on APB)
`define SADC_OFS_MODE0 12'h000
`define SADC_OFS_MODE1 12'h004
`define SADC_OFS_MODEC 12'h008
`define SADC_OFS_CHAN 12'h00C
`define SADC_OFS_RESW 12'h010
`define SADC_OFS_RESN 12'h014
`define SADC_OFS_UPLIM 12'h018
`define SADC_OFS_LOLIM 12'h01C
`define SADC_OFS_STAT 12'h020

// ==========================================================================
// Mode register 0 fields
`define SADC_M0_RUN 7
`define SADC_M0_CHMODE 6
`define SADC_M0_SHORT 0
`define SADC_M0_CMPEN 1
// Mode register 1 fields
`define SADC_M1_TRIG_LO 0
`define SADC_M1_ONESHOT 2
// Mode register C fields
`define SADC_MC_REFLO 0
`define SADC_MC_REFHI 1
`define SADC_MC_RES8 2
`define SADC_MC_RANGEOUT 3

// ==========================================================================
// Reset values and timing
`define SADC_UPLIM_RST 8'hFF
`define SADC_LOLIM_RST 8'h00
`define SADC_SAMPLE_LONG 7
`define SADC_SAMPLE_SHORT 5
`define SADC_STAB_NS 1000
`define SADC_CLK_NS 20
`define SADC_STAB_CYC ((`SADC_STAB_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_SCAN_CH 4

`endif

// ===== verilog/sadc_pkg.sv
/*
  Types of the converter controller.
  Assumes the definitions header is compiled alongside.
*/
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_TRIG_SW,
    SADC_TRIG_HWNOWAIT,
    SADC_TRIG_HWWAIT,
    SADC_TRIG_RSV
  } sadc_trig_e;

  typedef enum logic [2:0] {
    SADC_IDLE,
    SADC_STAB,
    SADC_SAMPLE,
    SADC_CONVERT,
    SADC_LOAD
  } sadc_state_e;

  typedef struct packed {
    logic        sampleOn;
    logic        compareOn;
    logic        powerOn;
    logic [4:0]  channel;
    logic [9:0]  tapCode;
    logic [1:0]  refSel;
  } sadc_analog_s;

endpackage

// ===== tb/sadc_asserts.sv
/* Port checker of the converter controller.
   Assumes binding into sadc_ctrl, clocked by clk, reset by nrst. */
`timescale 1ns/1ps
module sadc_asserts #(
  parameter int RES_BITS = 10,
  parameter int SCAN_CH = 4
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cmpAbove,
  input wire sadc_pkg::sadc_analog_s analogCtl,
  input wire logic conversionEndIrq
);
  wire samp = analogCtl.sampleOn;
  wire cmp = analogCtl.compareOn;
  wire [1:0] refData = pwdata[1:0];
  logic runOn;
  // ========
  // Software run shadow
  // A software stop may cut a sampling phase short, so the length check stands down.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      runOn <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      runOn <= pwdata[7];
  end
  // ========
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_irq_pulse: assert property (conversionEndIrq |=> !conversionEndIrq)
    else $error("end request longer than one cycle");
  chk_sample_len: assert property (disable iff (!nrst || !runOn)
    $rose(samp) |-> samp[*5] ##1 (!samp or samp[*2] ##1 !samp))
    else $error("sampling length wrong");
  chk_compare_len: assert property ($rose(cmp) |-> cmp[*8] ##1
    (!cmp or cmp[*2] ##1 !cmp)) else $error("compare cycle count wrong");
  chk_first_tap: assert property ($rose(cmp) |-> analogCtl.tapCode == 10'h200)
    else $error("first tap not half reference");
  chk_second_tap: assert property ($rose(cmp) ##1 cmp |->
    analogCtl.tapCode[9:7] == {$past(cmpAbove), 2'b10}) else $error("second tap wrong");
  chk_irq_load: assert property (conversionEndIrq |-> $past(cmp, 2) && !$past(cmp))
    else $error("end request not after load");
  chk_ref_sel: assert property (psel && penable && pwrite && paddr == 12'h008
    |=> analogCtl.refSel == $past(refData)) else $error("reference select wrong");
  chk_chan_hold: assert property (cmp |-> $stable(analogCtl.channel))
    else $error("channel moved during compare");
endmodule

bind sadc_ctrl sadc_asserts #(.RES_BITS(RES_BITS), .SCAN_CH(SCAN_CH)) sadc_asserts_inst (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .cmpAbove(cmpAbove), .analogCtl(analogCtl),
  .conversionEndIrq(conversionEndIrq));

// ===== tb/sadc_analog_model.sv
/* Behavioural sample-hold and comparator against the controller's tap code.
   Assumes the controller's analog bundle; each channel adds four steps to vin. */
`timescale 1ns/1ps
module sadc_analog_model (
  input wire logic clk,
  input wire sadc_pkg::sadc_analog_s analogCtl,
  input wire logic [9:0] vin,
  output logic cmpAbove
);
  logic [9:0] held = 10'h000;
  logic noise = 1'b0;
  // ========
  // Hold and compare
  always @(posedge clk)
  begin
    noise <= ~noise;
    if (analogCtl.sampleOn)
      held <= vin + 10'({analogCtl.channel, 2'b00});
  end
  // Outside compare cycles the line toggles, so a stale level is never trusted.
  // at or above
  assign cmpAbove = analogCtl.compareOn ? (held >= analogCtl.tapCode) : noise;
endmodule

// ===== tb/tb_top.sv
/* Self-checking bench of the converter controller.
   Assumes the analog model on the far side and APB with zero wait. */
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic hwTrigger = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0] vin = 10'h000;
  logic [31:0] prdata, rd, seed;
  logic pready, pslverr, err, cmpAbove, conversionEndIrq;
  sadc_pkg::sadc_analog_s analogCtl;
  int nMismatch = 0;
  int samplesChecked = 0;
  int nIrq = 0;
  logic [4:0] chSeen[$];
  logic sampPrev = 1'b0;
  sadc_ctrl sadc_ctrl_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hwTrigger(hwTrigger), .cmpAbove(cmpAbove), .analogCtl(analogCtl),
    .conversionEndIrq(conversionEndIrq));
  sadc_analog_model sadc_analog_model_inst (.clk(clk), .analogCtl(analogCtl), .vin(vin),
    .cmpAbove(cmpAbove));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Counting on the falling edge keeps clear of the rising-edge updates.
  always @(negedge clk)
  begin
    if (conversionEndIrq === 1'b1)
      nIrq++;
    if (analogCtl.sampleOn === 1'b1 && sampPrev !== 1'b1)
      chSeen.push_back(analogCtl.channel);
    sampPrev <= analogCtl.sampleOn;
  end
  // ========
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [9:0] expRes(input logic [9:0] v, input logic [4:0] ch);
    return v + 10'({ch, 2'b00});
  endfunction
  task automatic giveVerdict;
    $display("mismatches %0d comparisons %0d", nMismatch, samplesChecked);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (i >= 20)
    begin
      nMismatch++;
      giveVerdict();
    end
  endtask
  task automatic waitIrq(input int target, input int lim);
    for (int i = 0; i < lim && nIrq < target; i++)
      @(posedge clk);
    if (nIrq < target)
    begin
      nMismatch++;
      giveVerdict();
    end
  endtask
  // The comparator is enabled before run, as the pair must never be run-only.
  // enable order
  task automatic start(input logic [31:0] m1, mc, ch, m0);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, m1);
    apb(1'b1, 12'h008, mc);
    apb(1'b1, 12'h00C, ch);
    apb(1'b1, 12'h000, 32'h0000_0002 | m0);
    nIrq = 0;
    apb(1'b1, 12'h000, 32'h0000_0082 | m0);
  endtask
  task automatic trig;
    hwTrigger <= 1'b1;
    @(posedge clk);
    hwTrigger <= 1'b0;
  endtask
  // ========
  // Scenarios
  initial
  begin
    logic [4:0] ch;
    seed = 32'h2b2c_22c5;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    cmp(err, 1);
    cmp(rd, 0);
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      vin <= seed[9:0];
      ch = seed[12] ? 5'h1F : {3'b000, seed[11:10]};
      start(32'h4, {seed[13], seed[16:15]}, ch, seed[14]);
      waitIrq(1, 100);
      apb(1'b0, 12'h014, 32'h0000_0000);
      cmp(rd, expRes(seed[9:0], ch) >> 2);
      apb(1'b0, 12'h010, 32'h0000_0000);
      if (!seed[13])
        cmp(rd, {expRes(seed[9:0], ch), 6'h00});
      else
        cmp(rd, {expRes(seed[9:0], ch) & 10'h3FC, 6'h00});
      repeat (40) @(posedge clk);
      cmp(nIrq, 1);
      apb(1'b0, 12'h000, 32'h0000_0000);
      cmp(rd & 32'h0000_0080, 0);
    end
    start(32'h0, 32'h1, 32'h2, 32'h0);
    waitIrq(3, 200);
    apb(1'b1, 12'h000, 32'h0000_0002);
    nIrq = 0;
    repeat (60) @(posedge clk);
    cmp(nIrq, 0);
    chSeen.delete();
    start(32'h4, 32'h1, 32'h4, 32'h40);
    waitIrq(1, 300);
    repeat (60) @(posedge clk);
    cmp(nIrq, 1);
    cmp(chSeen.size(), 4);
    for (int i = 0; i < 4; i++)
      cmp(chSeen[i], 4 + i);
    apb(1'b0, 12'h014, 32'h0000_0000);
    cmp(rd, expRes(vin, 5'h07) >> 2);
    apb(1'b0, 12'h020, 32'h0000_0000);
    cmp(rd, 32'h0000_0008);
    start(32'h1, 32'h1, 32'h0, 32'h0);
    repeat (40) @(posedge clk);
    cmp(nIrq, 0);
    trig();
    waitIrq(1, 60);
    start(32'h2, 32'h1, 32'h1, 32'h0);
    repeat (20) @(posedge clk);
    cmp(analogCtl.powerOn, 0);
    trig();
    repeat (2) @(posedge clk);
    cmp(analogCtl.powerOn, 1);
    waitIrq(1, 150);
    vin <= 10'h100;
    apb(1'b1, 12'h018, 32'h0000_0030);
    start(32'h4, 32'h1, 32'h0, 32'h0);
    repeat (60) @(posedge clk);
    cmp(nIrq, 0);
    start(32'h4, 32'h9, 32'h0, 32'h0);
    waitIrq(1, 60);
    giveVerdict();
  end
endmodule
